// [design/sbc_pkg.sv]
package sbc_pkg;
   // Control/status register location
   localparam logic [7:0] CSR_ADDR  = 8'hC0;
   localparam logic [3:0] CSR_PAGE  = 4'hF;
   localparam logic [7:0] CSR_RESET = 8'h00;
   // Field positions
   localparam int B_ROLE = 7;
   localparam int B_DIR  = 6;
   localparam int B_BEG  = 5;
   localparam int B_HALT = 4;
   localparam int B_RREQ = 3;
   localparam int B_LOSS = 2;
   localparam int B_ACK  = 1;
   localparam int B_EVT  = 0;
   // Link events, one toggle each
   localparam int EV_SGEN  = 0;
   localparam int EV_PGEN  = 1;
   localparam int EV_SDET  = 2;
   localparam int EV_ADDR  = 3;
   localparam int EV_PSLV  = 4;
   localparam int EV_ARB   = 5;
   localparam int EV_ARBP  = 6;
   localparam int EV_ACKL  = 7;
   localparam int EV_ACKH  = 8;
   localparam int EV_BRX   = 9;
   localparam int EV_ACKD  = 10;
   localparam int EV_FRAME = 11;
   localparam int NEV      = 12;
   localparam logic [NEV-1:0] EVT_SET_MASK = 12'h3F9;

   typedef struct packed {
      logic start_gen;
      logic stop_gen;
      logic start_det;
      logic rep_start_det;
      logic stop_det;
      logic addr_rx;
      logic byte_tx_done;
      logic byte_rx;
      logic ack_done;
      logic frame_start;
      logic cond_try;
      logic tx_one;
      logic ack_phase;
      logic addressed;
      logic scl_pull;
      logic sda_pull;
   } sbc_eng_t;

   typedef struct packed {
      logic ctrl;
      logic tx;
      logic start_req;
      logic stop_req;
      logic stall;
      logic ack_val;
      logic drive_ack;
   } sbc_cmd_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [3:0] page;
      logic       wr;
      logic       bit_wr;
      logic [2:0] bit_idx;
      logic [7:0] wdata;
   } sbc_sfr_t;
endpackage

// [design/sbc_ctrl_status.sv]
`timescale 1ns/1ps
// Contract
// (RQ1) Bit 7 read-only: 1 controller, 0 target
// (RQ2) Role set on START, cleared STOP/loss
// (RQ3) Bit 6 read-only: 1 transmit, 0 receive
// (RQ4) Direction set START/early data, cleared otherwise
// (RQ5) Writing bit 5 high requests START
// (RQ6) Start flag set on START+address; software clears
// (RQ7) Stop flag requests STOP; cleared when sent
// (RQ8) Stop flag set on target/lost STOP
// (RQ9) Bit 3 set on received byte, manual mode
// (RQ10) Loss on low clock or data line
// (RQ11) Loss on unwanted repeated START; cleared with event
// (RQ12) Bit 1 holds incoming ack; write sends it
// (RQ13) Event flag set on listed bus events
// (RQ14) Software clears event flag; one forces it
// (RQ15) Event flag holds clock line low
// (RQ16) Register 0xC0 page F, resets zero
// (RQ17) Manual mode: no ack write sends NACK
// (RQ18) Auto mode drives ack bit, no request
// (RQ19) Ack write drives data line at once
// (RQ20) Open-drain lines: pull low or release
module sbc_ctrl_status
   import sbc_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              link_clk_i,
   input  wire sbc_pkg::sbc_sfr_t sfr_i,
   output logic [7:0]             sfr_rdata_o,
   input  wire logic              data_wr_i,
   input  wire logic              auto_ack_en_i,
   output logic                   event_pending_o,
   input  wire sbc_pkg::sbc_eng_t eng_i,
   output sbc_pkg::sbc_cmd_t      cmd_o,
   input  wire logic              scl_i,
   output logic                   scl_o,
   output logic                   scl_oe_o,
   input  wire logic              sda_i,
   output logic                   sda_o,
   output logic                   sda_oe_o
);
   import sbc_pkg::*;

   // Write strobe for one bit, byte or bit access
   function automatic logic wr_hit(input sbc_sfr_t s, input logic sel, input int i);
      wr_hit = sel & (s.wr | (s.bit_wr & (s.bit_idx == i[2:0])));
   endfunction

   function automatic logic wr_val(input sbc_sfr_t s, input int i);
      wr_val = s.bit_wr ? s.wdata[0] : s.wdata[i];
   endfunction

   // Link side
   logic           lrst_m;
   logic           lrst_n;
   logic           scl_m;
   logic           scl_s;
   logic           sda_m;
   logic           sda_s;
   sbc_cmd_t       cmd_m;
   sbc_cmd_t       cmd_s;
   logic           arb_q;
   logic [NEV-1:0] tog;
   logic           scl_oe;
   logic           sda_oe;

   // System side
   logic [NEV-1:0] tog_m;
   logic [NEV-1:0] tog_s;
   logic [NEV-1:0] tog_q;
   logic           ctrl;
   logic           tx;
   logic           sta;
   logic           sto;
   logic           ackrq;
   logic           arb;
   logic           ack;
   logic           si;
   logic           dat_pend;
   logic           ack_wr;
   logic [7:0]     rdata;
   sbc_cmd_t       cmd_sys;

   // Link clock domain
   wire            arb_lvl;
   wire            arb_rs;
   wire            arb_stop;
   wire [NEV-1:0]  ev;

   // Reset release is resynchronised; link clock may stop between frames
   always_ff @(posedge link_clk_i)
   begin
      lrst_m <= rst_n_i;
      lrst_n <= lrst_m;
      scl_m  <= scl_i;
      scl_s  <= scl_m;
      sda_m  <= sda_i;
      sda_s  <= sda_m;
      cmd_m  <= cmd_sys;
      cmd_s  <= cmd_m;
   end

   // (RQ10) Sampled line contention
   assign arb_lvl = (eng_i.cond_try & ~scl_s)
                  | (eng_i.tx_one & ~eng_i.ack_phase & ~sda_s);
   // (RQ11) Unrequested repeated START
   assign arb_rs = eng_i.rep_start_det & cmd_s.ctrl & ~cmd_s.start_req;
   // (RQ8) STOP seen while controlling
   assign arb_stop = eng_i.stop_det & cmd_s.ctrl & ~cmd_s.stop_req;

   assign ev[EV_SGEN]  = eng_i.start_gen;
   assign ev[EV_PGEN]  = eng_i.stop_gen;
   assign ev[EV_SDET]  = eng_i.start_det | eng_i.rep_start_det;
   assign ev[EV_ADDR]  = eng_i.addr_rx;
   assign ev[EV_PSLV]  = eng_i.stop_det & eng_i.addressed;
   assign ev[EV_ARB]   = (arb_lvl & ~arb_q) | arb_rs;
   assign ev[EV_ARBP]  = arb_stop;
   assign ev[EV_ACKL]  = eng_i.byte_tx_done & ~sda_s;
   assign ev[EV_ACKH]  = eng_i.byte_tx_done & sda_s;
   assign ev[EV_BRX]   = eng_i.byte_rx;
   assign ev[EV_ACKD]  = eng_i.ack_done;
   assign ev[EV_FRAME] = eng_i.frame_start;

   always_ff @(posedge link_clk_i)
   begin
      if (!lrst_n)
      begin
         arb_q  <= 1'b0;
         tog    <= '0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
      end
      else
      begin
         arb_q  <= arb_lvl;
         tog    <= tog ^ ev;
         // (RQ15) Stall holds clock low
         scl_oe <= eng_i.scl_pull | cmd_s.stall;
         // (RQ19) Ack value drives data
         sda_oe <= eng_i.sda_pull
                 | (eng_i.ack_phase & cmd_s.drive_ack & cmd_s.ack_val);
      end
   end

   // (RQ20) Open-drain: only pull low
   assign scl_o    = 1'b0;
   assign sda_o    = 1'b0;
   assign scl_oe_o = scl_oe;
   assign sda_oe_o = sda_oe;
   assign cmd_o    = cmd_s;

   // System clock domain
   wire [NEV-1:0] evp;
   wire           sel;
   wire           w_sta;
   wire           w_sto;
   wire           w_ack;
   wire           w_si;
   wire           v_sta;
   wire           v_sto;
   wire           v_ack;
   wire           v_si;
   wire           si_set;
   wire           si_clr;
   wire           lost;
   wire [7:0]     csr;

   always_ff @(posedge clk_i)
   begin
      tog_m <= tog;
      tog_s <= tog_m;
   end

   // Toggles cross as events; one pulse per link event
   assign evp = tog_s ^ tog_q;

   // (RQ16) Register decode
   assign sel   = (sfr_i.addr == CSR_ADDR) & (sfr_i.page == CSR_PAGE);
   assign w_sta = wr_hit(sfr_i, sel, B_BEG);
   assign w_sto = wr_hit(sfr_i, sel, B_HALT);
   assign w_ack = wr_hit(sfr_i, sel, B_ACK);
   assign w_si  = wr_hit(sfr_i, sel, B_EVT);
   assign v_sta = wr_val(sfr_i, B_BEG);
   assign v_sto = wr_val(sfr_i, B_HALT);
   assign v_ack = wr_val(sfr_i, B_ACK);
   assign v_si  = wr_val(sfr_i, B_EVT);

   // (RQ13) Event flag sources
   assign si_set = |(evp & EVT_SET_MASK);
   // (RQ14) Clear only by software write
   assign si_clr = w_si & ~v_si & ~si_set;
   assign lost   = evp[EV_ARB] | evp[EV_ARBP];

   // (RQ1) Read-only status bits
   // (RQ3) Direction read-only too
   assign csr = {ctrl, tx, sta, sto, ackrq, arb, ack, si};

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         tog_q    <= '0;
         // (RQ16) All bits reset zero
         {ctrl, tx, sta, sto, ackrq, arb, ack, si} <= CSR_RESET;
         dat_pend <= 1'b0;
         ack_wr   <= 1'b0;
         rdata    <= CSR_RESET;
      end
      else
      begin
         tog_q <= tog_s;
         rdata <= sel ? csr : 8'h00;

         // (RQ2) Role tracking
         if (lost | evp[EV_PGEN])
            ctrl <= 1'b0;
         else if (evp[EV_SGEN])
            ctrl <= 1'b1;

         // (RQ4) Direction tracking
         if (evp[EV_SGEN])
            tx <= 1'b1;
         else if (evp[EV_SDET] | lost)
            tx <= 1'b0;
         else if (evp[EV_FRAME])
            tx <= dat_pend;

         // Data write noted until frame start
         if (data_wr_i)
            dat_pend <= 1'b1;
         else if (evp[EV_FRAME])
            dat_pend <= 1'b0;

         // (RQ6) Hardware only sets start
         if (evp[EV_ADDR])
            sta <= 1'b1;
         // (RQ5) Software start request
         else if (w_sta)
            sta <= v_sta;

         // (RQ8) Stop detect sets
         if (evp[EV_PSLV] | evp[EV_ARBP])
            sto <= 1'b1;
         // (RQ7) Cleared once sent
         else if (evp[EV_PGEN])
            sto <= 1'b0;
         else if (w_sto)
            sto <= v_sto;

         // (RQ9) Manual response request
         if (evp[EV_BRX] & ~auto_ack_en_i)
            ackrq <= 1'b1;
         else if (evp[EV_ACKD])
            ackrq <= 1'b0;

         // (RQ11) Loss cleared with event
         if (lost)
            arb <= 1'b1;
         else if (si_clr)
            arb <= 1'b0;

         // (RQ12) Incoming ack captured
         if (evp[EV_ACKL])
            ack <= 1'b1;
         else if (evp[EV_ACKH])
            ack <= 1'b0;
         else if (w_ack)
            ack <= v_ack;
         // (RQ17) Unanswered request sends NACK
         else if (si_clr & ackrq & ~ack_wr)
            ack <= 1'b0;

         if (w_ack)
            ack_wr <= 1'b1;
         else if (evp[EV_BRX])
            ack_wr <= 1'b0;

         // (RQ14) Set wins over clear
         if (si_set)
            si <= 1'b1;
         else if (w_si)
            si <= v_si;
      end
   end

   // Commands to the bus engine
   always_comb
   begin
      cmd_sys.ctrl      = ctrl;
      cmd_sys.tx        = tx;
      cmd_sys.start_req = sta;
      // (RQ7) Stop only as controller
      cmd_sys.stop_req  = sto & ctrl;
      cmd_sys.stall     = si;
      cmd_sys.ack_val   = ack;
      // (RQ18) Ack driven when receiving
      cmd_sys.drive_ack = ~tx;
   end

   assign sfr_rdata_o     = rdata;
   assign event_pending_o = si;
endmodule

// [testbench/sbc_bus_model.sv]
`timescale 1ns/1ps
module sbc_bus_model
(
   input  wire logic scl_oe_i,
   input  wire logic sda_oe_i,
   input  wire logic hold_sda_i,
   output logic      scl_o,
   output logic      sda_o
);
   assign scl_o = !scl_oe_i;
   assign sda_o = !(sda_oe_i || hold_sda_i);
endmodule

// [testbench/sbc_ctrl_status_checker.sv]
`timescale 1ns/1ps
module sbc_ctrl_status_checker
   import sbc_pkg::*;
(
   input wire logic              clk_i,
   input wire logic              rst_n_i,
   input wire logic              link_clk_i,
   input wire sbc_pkg::sbc_sfr_t sfr_i,
   input wire logic [7:0]        sfr_rdata_o,
   input wire logic              event_pending_o,
   input wire sbc_pkg::sbc_eng_t eng_i,
   input wire sbc_pkg::sbc_cmd_t cmd_o,
   input wire logic              scl_o,
   input wire logic              scl_oe_o,
   input wire logic              sda_o,
   input wire logic              sda_oe_o
);
   wire sel = sfr_i.addr == CSR_ADDR && sfr_i.page == CSR_PAGE;
   wire set_evt = sel && (sfr_i.wr || (sfr_i.bit_wr && sfr_i.bit_idx == 3'h0));
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   unmapped_zero_a: assert property (
      !sel |=> sfr_rdata_o == 8'h00) else $error("unselected read not zero");
   evt_force_a: assert property (
      set_evt && sfr_i.wdata[0] |=> event_pending_o) else $error("event not forced");
   stall_hold_a: assert property (@(posedge link_clk_i)
      event_pending_o [*8] |-> scl_oe_o) else $error("clock not held low");
   stall_free_a: assert property (@(posedge link_clk_i)
      (!event_pending_o && !eng_i.scl_pull) [*8] |-> !scl_oe_o) else $error("clock held");
   ack_drive_a: assert property (@(posedge link_clk_i)
      (eng_i.ack_phase && !cmd_o.tx && cmd_o.ack_val) [*5] |-> sda_oe_o) else $error("no ack");
   sda_free_a: assert property (@(posedge link_clk_i)
      (!eng_i.sda_pull && !eng_i.ack_phase) [*5] |-> !sda_oe_o) else $error("data held");
   pins_low_a: assert property (
      !scl_o && !sda_o) else $error("pin drives high");
   ack_dir_a: assert property (@(posedge link_clk_i)
      cmd_o.drive_ack == !cmd_o.tx) else $error("ack drive with transmit");
endmodule

// [testbench/smbus_control_status_flags_tb_top.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module smbus_control_status_flags_tb_top;
   import sbc_pkg::*;
   localparam int SGEN = 15, REP = 12, PDET = 11, ADDR = 10, TXD = 9, RXB = 8, ACKD = 7, FRM = 6;
   localparam int PGEN = 14;
   logic     clk_i = 0, rst_n_i = 0, link_clk_i = 0, data_wr_i = 0, auto_ack_en_i = 0;
   logic     hold_sda = 0, scl_i, sda_i, scl_o, sda_o, scl_oe_o, sda_oe_o, event_pending_o;
   logic [7:0] sfr_rdata_o;
   sbc_sfr_t sfr_i = '0;
   sbc_eng_t eng_i = '0, lvl = '0;
   sbc_cmd_t cmd_o;
   int       num_errors = 0, num_checks = 0, cyc = 0;
   initial forever #50 clk_i = !clk_i;
   initial
   begin
      #1.3;
      forever #3 link_clk_i = !link_clk_i;
   end
   sbc_ctrl_status dut (.clk_i, .rst_n_i, .link_clk_i, .sfr_i, .sfr_rdata_o, .data_wr_i,
      .auto_ack_en_i, .event_pending_o, .eng_i, .cmd_o, .scl_i, .scl_o, .scl_oe_o, .sda_i,
      .sda_o, .sda_oe_o);
   sbc_bus_model bus (.scl_oe_i(scl_oe_o), .sda_oe_i(sda_oe_o), .hold_sda_i(hold_sda),
      .scl_o(scl_i), .sda_o(sda_i));
   task automatic sfr(logic [7:0] a, logic w, logic b, logic [2:0] i, logic [7:0] d);
      @(posedge clk_i);
      #1 sfr_i = '{a, 4'hF, w, b, i, d};
      @(posedge clk_i);
      #1 sfr_i.wr = 0;
      sfr_i.bit_wr = 0;
   endtask
   task automatic rd(logic [7:0] e);
      sfr(8'hC0, 0, 0, 0, 0);
      `CHK(sfr_rdata_o, e)
   endtask
   task automatic bw(logic [2:0] i, logic v);
      sfr(8'hC0, 0, 1, i, {7'h00, v});
   endtask
   // Events spaced by 2 us, well over the sync gap
   task automatic ev(int b);
      @(posedge link_clk_i);
      #1 eng_i = lvl;
      eng_i[b] = 1;
      @(posedge link_clk_i);
      #1 eng_i = lvl;
      repeat (20) @(posedge clk_i);
   endtask
   task automatic t_regs();
      rd(8'h00);
      sfr(8'hC1, 1, 0, 0, 8'hFF);
      `CHK(sfr_rdata_o, 8'h00)
      sfr(8'hC0, 1, 0, 0, 8'hFF);
      rd(8'h33);
      sfr(8'hC0, 1, 0, 0, 8'h00);
      rd(8'h00);
   endtask
   task automatic t_ctrl();
      ev(SGEN);
      rd(8'hC1);
      `CHK(scl_oe_o, 1'b1)
      bw(0, 0);
      rd(8'hC0);
      `CHK(scl_oe_o, 1'b0)
      bw(5, 1);
      bw(4, 1);
      rd(8'hF0);
      `CHK({cmd_o.start_req, cmd_o.stop_req}, 2'b11)
      ev(PGEN);
      rd(8'h60);
      `CHK(cmd_o.stop_req, 1'b0)
      ev(SGEN);
      bw(5, 0);
      bw(0, 0);
      rd(8'hC0);
      `CHK(cmd_o.start_req, 1'b0)
      hold_sda = 1;
      #200 ev(TXD);
      rd(8'hC3);
      hold_sda = 0;
      bw(0, 0);
      ev(TXD);
      rd(8'hC1);
      bw(0, 0);
      ev(REP);
      rd(8'h05);
      bw(0, 0);
      rd(8'h00);
      // Data line pulled low while sending a one
      lvl.tx_one = 1;
      eng_i = lvl;
      hold_sda = 1;
      repeat (20) @(posedge clk_i);
      rd(8'h05);
      lvl.tx_one = 0;
      eng_i = lvl;
      hold_sda = 0;
      bw(0, 0);
      rd(8'h00);
   endtask
   task automatic t_rx();
      ev(RXB);
      rd(8'h09);
      lvl.ack_phase = 1;
      eng_i = lvl;
      bw(1, 1);
      repeat (3) @(posedge clk_i);
      `CHK({sda_oe_o, scl_oe_o}, 2'b11)
      bw(0, 0);
      ev(ACKD);
      lvl.ack_phase = 0;
      eng_i = lvl;
      rd(8'h02);
      ev(RXB);
      bw(0, 0);
      ev(ACKD);
      rd(8'h00);
      auto_ack_en_i = 1;
      ev(RXB);
      rd(8'h01);
   endtask
   task automatic t_target();
      lvl.addressed = 1;
      ev(ADDR);
      rd(8'h21);
      bw(0, 0);
      ev(PDET);
      rd(8'h31);
      data_wr_i = 1;
      @(posedge clk_i);
      #1 data_wr_i = 0;
      ev(FRM);
      rd(8'h71);
      ev(FRM);
      rd(8'h31);
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         num_errors++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (10) @(posedge clk_i);
      #1 rst_n_i = 1;
      t_regs();
      t_ctrl();
      t_rx();
      t_target();
      give_verdict();
   end
endmodule
bind sbc_ctrl_status sbc_ctrl_status_checker chk (.clk_i, .rst_n_i, .link_clk_i, .sfr_i,
   .sfr_rdata_o, .event_pending_o, .eng_i, .cmd_o, .scl_o, .scl_oe_o, .sda_o, .sda_oe_o);
